/* File: fan_lut_entries_nine_ten.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Low-res temperature mode: threshold top bit unused, reads zero.
// - High-res temperature mode: 8-bit threshold, 0 to 127.5 C, half steps.
// - Low-res temperature mode: lower seven bits are whole degrees, 0 to 127.
// - Reading above ninth threshold but not above tenth drives PWM with ninth duty.
// - Reading above tenth threshold drives PWM with tenth duty.
// - Compare upper 9 reading bits high-res, upper 8 bits low-res.
// - Thresholds are positive only; sign bit assumed zero.
// - Table temperature offset adds to thresholds for higher limits.
// - Low-res duty mode: duty top two bits unused, read zero.
// - High-res duty mode: top two bits join lower six into duty.
// - Extended duty bits act only at the 22.5 kHz setting.
// - Low-res duty mode: lower six duty bits are the PWM value.
module fan_lut_entries_nine_ten
	import fan_lut_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire fan_lut_pkg::apb_req_t apb_req,
	output fan_lut_pkg::apb_rsp_t      apb_rsp,
	input  wire logic [10:0]          remote_temp,
	output logic [7:0]                pwm_duty,
	output logic                      pwm_duty_valid
);
	import fan_lut_pkg::*;

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [7:0]        thresh_nine_r;
	logic [7:0]        duty_nine_r;
	logic [7:0]        thresh_ten_r;
	logic [7:0]        duty_ten_r;
	logic [15:0]       ctrl_r;
	entry_sel_t        sel_r;
	apb_rsp_t          rsp_r;
	logic [7:0]        duty_r;
	logic              valid_r;

	logic              wr_en;
	logic              temp_hires;
	logic              duty_hires;
	logic              ext_ok;
	logic [7:0]        table_ofs;
	logic [7:0]        word_idx;
	logic              acc_wr;
	logic              acc_rd;

	assign wr_en      = ctrl_r[CTRL_WR_EN];
	assign temp_hires = ctrl_r[CTRL_TEMP_HIRES];
	assign duty_hires = ctrl_r[CTRL_DUTY_HIRES];
	assign table_ofs  = ctrl_r[CTRL_OFS_LSB +: 8];
	assign ext_ok     = duty_hires && (ctrl_r[CTRL_FREQ_LSB +: FREQ_W] == FREQ_22K5);
	assign word_idx   = apb_req.paddr[9:2];
	assign acc_wr     = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign acc_rd     = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// ****************************************************************
	// Read-side views of the table entries
	// ****************************************************************
	function automatic logic [7:0] thresh_view(input logic [7:0] t, input logic hi);
		thresh_view = hi ? t : {1'b0, t[6:0]};
	endfunction : thresh_view

	function automatic logic [7:0] duty_view(input logic [7:0] d, input logic hi);
		duty_view = hi ? d : {2'b00, d[5:0]};
	endfunction : duty_view

	// ****************************************************************
	// Control register and table writes
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= {8'h00, RST_CTRL};
		end else if (acc_wr && word_idx == IDX_TABLE_CTRL) begin
			ctrl_r <= apb_req.pwdata[15:0];
		end
	end

	// Writes with the enable clear are accepted on the bus but dropped,
	// so software sees no error, only an unchanged entry.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thresh_nine_r <= RST_THRESH;
			duty_nine_r   <= RST_DUTY;
			thresh_ten_r  <= RST_THRESH;
			duty_ten_r    <= RST_DUTY;
		end else if (acc_wr && wr_en) begin
			if (word_idx == IDX_THRESH_NINE) begin
				thresh_nine_r <= apb_req.pwdata[7:0];
			end else if (word_idx == IDX_DUTY_NINE) begin
				duty_nine_r <= apb_req.pwdata[7:0];
			end else if (word_idx == IDX_THRESH_TEN) begin
				thresh_ten_r <= apb_req.pwdata[7:0];
			end else if (word_idx == IDX_DUTY_TEN) begin
				duty_ten_r <= apb_req.pwdata[7:0];
			end
		end
	end

	// ****************************************************************
	// APB response: no wait states, read data loaded in setup
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_r <= '0;
		end else begin
			rsp_r.pready <= apb_req.psel && !apb_req.penable;
			if (acc_rd) begin
				rsp_r.pslverr <= 1'b0;
				if (word_idx == IDX_THRESH_NINE) begin
					rsp_r.prdata <= {24'h000000, thresh_view(thresh_nine_r, temp_hires)};
				end else if (word_idx == IDX_DUTY_NINE) begin
					rsp_r.prdata <= {24'h000000, duty_view(duty_nine_r, duty_hires)};
				end else if (word_idx == IDX_THRESH_TEN) begin
					rsp_r.prdata <= {24'h000000, thresh_view(thresh_ten_r, temp_hires)};
				end else if (word_idx == IDX_DUTY_TEN) begin
					rsp_r.prdata <= {24'h000000, duty_view(duty_ten_r, duty_hires)};
				end else if (word_idx == IDX_TABLE_CTRL) begin
					rsp_r.prdata <= {16'h0000, ctrl_r};
				end else if (word_idx == IDX_TABLE_STAT) begin
					rsp_r.prdata <= {22'h000000, sel_r, duty_r};
				end else begin
					rsp_r.prdata  <= 32'h00000000;
					rsp_r.pslverr <= 1'b1;
				end
			end else if (apb_req.psel && !apb_req.penable) begin
				rsp_r.prdata  <= 32'h00000000;
				rsp_r.pslverr <= !(word_idx == IDX_THRESH_NINE || word_idx == IDX_DUTY_NINE ||
					word_idx == IDX_THRESH_TEN || word_idx == IDX_DUTY_TEN ||
					word_idx == IDX_TABLE_CTRL || word_idx == IDX_TABLE_STAT);
			end
		end
	end

	assign apb_rsp = rsp_r;

	// ****************************************************************
	// Threshold compare
	// ****************************************************************
	// Everything is compared in half degrees, 10 bits wide, so the
	// offset can push a limit past 127.5 C without wrapping.
	logic [9:0] reading_half;
	logic [9:0] limit_nine;
	logic [9:0] limit_ten;
	logic       above_nine;
	logic       above_ten;

	function automatic logic [9:0] limit_of(input logic [7:0] t, input logic hi,
		input logic [7:0] ofs);
		logic [9:0] base;
		base = hi ? {2'b00, t[6:0], t[7]} : {2'b00, t[6:0], 1'b0};
		limit_of = base + {1'b0, ofs, 1'b0};
	endfunction : limit_of

	// Reading is 11 bits in eighths of a degree, unsigned; the low three
	// bits are dropped in low-res and two in high-res.
	assign reading_half = temp_hires ? {1'b0, remote_temp[10:2]}
		: {1'b0, remote_temp[10:3], 1'b0};
	assign limit_nine   = limit_of(thresh_nine_r, temp_hires, table_ofs);
	assign limit_ten    = limit_of(thresh_ten_r, temp_hires, table_ofs);
	assign above_nine   = reading_half > limit_nine;
	assign above_ten    = reading_half > limit_ten;

	// ****************************************************************
	// Duty selection
	// ****************************************************************
	function automatic logic [7:0] duty_eff(input logic [7:0] d, input logic ext);
		duty_eff = ext ? d : {2'b00, d[5:0]};
	endfunction : duty_eff

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r   <= SEL_NONE;
			duty_r  <= 8'h00;
			valid_r <= 1'b0;
		end else if (above_ten) begin
			sel_r   <= SEL_TEN;
			duty_r  <= duty_eff(duty_ten_r, ext_ok);
			valid_r <= 1'b1;
		end else if (above_nine) begin
			sel_r   <= SEL_NINE;
			duty_r  <= duty_eff(duty_nine_r, ext_ok);
			valid_r <= 1'b1;
		end else begin
			sel_r   <= SEL_NONE;
			duty_r  <= 8'h00;
			valid_r <= 1'b0;
		end
	end

	assign pwm_duty       = duty_r;
	assign pwm_duty_valid = valid_r;

endmodule : fan_lut_entries_nine_ten

/* File: fan_lut_entries_nine_ten_monitor.sv */
`timescale 1ns/1ns
module fan_lut_checker
	import fan_lut_pkg::*;
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire fan_lut_pkg::apb_req_t apb_req,
	input wire fan_lut_pkg::apb_rsp_t apb_rsp,
	input wire logic [10:0]           remote_temp,
	input wire logic [7:0]            pwm_duty,
	input wire logic                  pwm_duty_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] idx;
	logic       rdy;
	assign idx = apb_req.paddr[9:2];
	assign rdy = apb_rsp.pready;
	AST_SETUP_READY: assert property (apb_req.psel && !apb_req.penable |=> rdy)
		else $error("no ready after setup");
	AST_READY_IN_ACCESS: assert property (rdy |-> apb_req.psel && apb_req.penable)
		else $error("ready outside access");
	AST_TABLE_NO_ERR: assert property (rdy && idx inside {[8'h60:8'h63]} |-> !apb_rsp.pslverr)
		else $error("table access refused");
	AST_UNMAPPED_ERR: assert property (rdy && !(idx inside {[8'h60:8'h63], 8'h70, 8'h71})
		|-> apb_rsp.pslverr) else $error("unmapped access accepted");
	AST_ERR_READS_ZERO: assert property (rdy && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
		else $error("error read not zero");
	AST_UPPER_ZERO: assert property (rdy |-> apb_rsp.prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	AST_IDLE_DUTY_ZERO: assert property (!pwm_duty_valid |-> pwm_duty == 8'h00)
		else $error("duty without valid entry");
	AST_COLD_NOT_VALID: assert property (remote_temp == 11'h000 |=> !pwm_duty_valid)
		else $error("zero reading exceeds threshold");
	AST_DUTY_HOLDS: assert property (($stable(remote_temp) && !apb_req.psel)[*2]
		|=> $stable(pwm_duty) && $stable(pwm_duty_valid)) else $error("duty moved");
	cover property ($rose(pwm_duty_valid));
	cover property (pwm_duty_valid && pwm_duty[7:6] != 2'h0);
	cover property (rdy && apb_rsp.pslverr);
endmodule : fan_lut_checker

bind fan_lut_entries_nine_ten fan_lut_checker i_chk (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .remote_temp(remote_temp),
	.pwm_duty(pwm_duty), .pwm_duty_valid(pwm_duty_valid));

/* File: fan_lut_entries_nine_ten_test.sv */
`timescale 1ns/1ns
module fan_lut_entries_nine_ten_test;
	import fan_lut_pkg::*;
	logic        pclk;
	logic        presetn;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic [10:0] remote_temp;
	logic [7:0]  pwm_duty;
	logic        pwm_duty_valid;
	logic [7:0]  sh[4] = '{8'h7F, 8'h3F, 8'h7F, 8'h3F};
	int          n_mismatch = 0;
	int          checks = 0;
	fan_lut_entries_nine_ten i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .remote_temp(remote_temp), .pwm_duty(pwm_duty),
		.pwm_duty_valid(pwm_duty_valid));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic [7:0] i, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		req <= '{paddr: {1'b0, i, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : xfer
	function automatic logic [7:0] dsel(input logic [15:0] c, input logic [7:0] d);
		return (c[2] && c[5:3] == FREQ_22K5) ? d : {2'b00, d[5:0]};
	endfunction : dsel
	function automatic logic [8:0] pwm_exp(input logic [15:0] c, input logic [10:0] tp);
		logic [9:0] rd;
		logic [9:0] l9;
		logic [9:0] l10;
		rd = c[1] ? {1'b0, tp[10:2]} : {1'b0, tp[10:3], 1'b0};
		l9 = {2'b00, sh[0][6:0], c[1] & sh[0][7]} + {1'b0, c[15:8], 1'b0};
		l10 = {2'b00, sh[2][6:0], c[1] & sh[2][7]} + {1'b0, c[15:8], 1'b0};
		if (rd > l10) return {1'b1, dsel(c, sh[3])};
		if (rd > l9) return {1'b1, dsel(c, sh[1])};
		return 9'h000;
	endfunction : pwm_exp
	task automatic run(input logic [15:0] c, input logic [7:0] v[4], input logic [10:0] tp);
		logic [31:0] q;
		logic        e;
		logic [8:0]  x;
		xfer(IDX_TABLE_CTRL, 1'b1, {16'h0000, c}, q, e);
		xfer(IDX_TABLE_CTRL, 1'b0, 32'h0, q, e);
		chk({e, q}, {17'h0, c}, "ctrl read back");
		for (int i = 0; i < 4; i++) begin
			xfer(8'(IDX_THRESH_NINE + i), 1'b1, {24'h000000, v[i]}, q, e);
			if (c[0]) sh[i] = v[i];
		end
		for (int i = 0; i < 4; i++) begin
			xfer(8'(IDX_THRESH_NINE + i), 1'b0, 32'h0, q, e);
			chk({e, q}, {25'h0, sh[i] & (i[0] ? (c[2] ? 8'hFF : 8'h3F) : (c[1] ? 8'hFF : 8'h7F))},
				"read back");
		end
		remote_temp <= tp;
		repeat (3) @(posedge pclk);
		chk({24'h0, pwm_duty_valid, pwm_duty}, {24'h0, pwm_exp(c, tp)},
			"duty");
		x = pwm_exp(c, tp);
		xfer(IDX_TABLE_STAT, 1'b0, 32'h0, q, e);
		chk({1'b0, e, q[31:10], |q[9:8], q[7:0]}, {2'b00, 22'h0, x}, "status");
		$display("test done ctrl %h temp %h", c, tp);
	endtask : run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [31:0] q;
		logic        e;
		logic [15:0] c;
		req = '0;
		remote_temp = 11'h000;
		presetn = 1'b0;
		void'($urandom(32'haa29));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		run(16'h0000, '{8'h11, 8'h22, 8'h33, 8'h44}, 11'h000);
		xfer(8'h40, 1'b0, 32'h0, q, e);
		chk({e, q}, 33'h1_0000_0000, "unmapped");
		run(16'h003F, '{8'h20, 8'hC5, 8'h40, 8'hFA}, 11'h104);
		run(16'h0039, '{8'h20, 8'hC5, 8'h40, 8'hFA}, 11'h104);
		run(16'h0005, '{8'h20, 8'hC5, 8'h30, 8'hFA}, 11'h208);
		for (int n = 0; n < 40; n++) begin
			c = {8'($urandom_range(0, 40)), 2'b00, 6'($urandom)};
			run(c, '{8'($urandom) & 8'h7F, 8'($urandom), 8'($urandom) & 8'h7F, 8'($urandom)},
				11'($urandom));
		end
		run(16'h0001, '{8'hA0, 8'hC5, 8'hFF, 8'hFA}, 11'h300);
		conclude();
	end
endmodule : fan_lut_entries_nine_ten_test

/* File: fan_lut_pkg.sv */
package fan_lut_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	// Offsets 0x61 and 0x63 are not word aligned, so every offset is kept
	// as a register index and the byte address is four times that index.
	localparam logic [7:0]  IDX_THRESH_NINE = 8'h60;
	localparam logic [7:0]  IDX_DUTY_NINE   = 8'h61;
	localparam logic [7:0]  IDX_THRESH_TEN  = 8'h62;
	localparam logic [7:0]  IDX_DUTY_TEN    = 8'h63;
	localparam logic [7:0]  IDX_TABLE_CTRL  = 8'h70;
	localparam logic [7:0]  IDX_TABLE_STAT  = 8'h71;

	localparam logic [7:0]  RST_THRESH      = 8'h7F;
	localparam logic [7:0]  RST_DUTY        = 8'h3F;
	localparam logic [7:0]  RST_CTRL        = 8'h00;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int          CTRL_WR_EN      = 0;
	localparam int          CTRL_TEMP_HIRES = 1;
	localparam int          CTRL_DUTY_HIRES = 2;
	localparam int          CTRL_FREQ_LSB   = 3;
	localparam int          FREQ_W          = 3;
	localparam int          CTRL_OFS_LSB    = 8;

	// Frequency code that selects the 22.5 kHz output.
	localparam logic [2:0]  FREQ_22K5       = 3'h7;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic [10:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_NINE,
		SEL_TEN
	} entry_sel_t;

endpackage : fan_lut_pkg
